// [rtl/psw_params.svh]
// constants of the programmable switch register map
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

// telegram field widths
`define PSW_CMD_W 3
`define PSW_ADR_W 4
`define PSW_DAT_W 14

// command codes
`define PSW_CMD_READ 3'h2
`define PSW_CMD_WRITE 3'h3
`define PSW_CMD_PROG 3'h4
`define PSW_CMD_ERASE 3'h5

// register addresses
`define PSW_ADR_LOW 4'h1
`define PSW_ADR_HIGH 4'h2
`define PSW_ADR_VOQ 4'h3
`define PSW_ADR_GAIN 4'h4
`define PSW_ADR_MODE 4'h5
`define PSW_ADR_LOCK 4'h6
`define PSW_ADR_CONV 4'h7
`define PSW_ADR_GPU 4'h8
`define PSW_ADR_SPATH 4'h9
`define PSW_ADR_TC 4'hB
`define PSW_ADR_GP0 4'hC
`define PSW_ADR_DISABLE 4'hF
`define PSW_ADR_STORE 4'h0

// deactivate key, last upper word index
`define PSW_DISABLE_KEY 12'h80F
`define PSW_GP_LAST 2'h2

// store timing
`define PSW_CLK_KHZ 200000
`define PSW_PROG_TIME_MS 100

`endif

// [rtl/psw_pkg.sv]
// types of the programmable switch register map
package psw_pkg;

    typedef struct packed {
        logic mag_range;
        logic offset_correction_sign;
        logic [2:0] output_behaviour_select;
        logic [1:0] filter;
        logic [1:0] range;
        logic offset_trim_enable;
    } psw_mode_s;

    typedef struct packed {
        logic [1:0] range_group;
        logic [4:0] linear_term;
        logic [2:0] second_order_temp_term;
    } psw_tc_s;

    typedef struct packed {
        logic [7:0] low_level;
        logic [8:0] high_level;
        logic [10:0] quiescent_output_offset;
        logic [13:0] magnetic_gain;
        psw_mode_s operating_configuration;
        psw_tc_s temperature_coefficient;
        logic [12:0] general_purpose_word_zero;
        logic [2:0][12:0] general_purpose_upper_words;
    } psw_cfg_s;

    typedef struct packed {
        logic [2:0] command;
        logic command_parity;
        logic [3:0] address;
        logic address_parity;
        logic [13:0] data_field;
        logic data_parity;
    } psw_tel_s;

    typedef struct packed {
        logic has_data;
        logic [13:0] data_field;
        logic data_parity;
    } psw_ans_s;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_RUN,
        ST_STORE
    } psw_state_e;

endpackage : psw_pkg

// [rtl/psw_parity.sv]
// parity over a field, counted on zero bits
`timescale 1ns/10ps
module psw_parity #(
    parameter int unsigned W = 4,
    parameter bit ODD_ZEROS = 1'b1
) (
    // field and its parity
    input wire logic [W-1:0] bits_i,
    output logic par_o
);
    generate
        if (W < 1) begin : g_chk
            $error("psw_parity: width must be at least one");
        end
    endgenerate

    // xor of inverted bits is one when the count of zeros is odd
    always_comb begin
        par_o = ODD_ZEROS ? ^(~bits_i) : ~^(~bits_i);
    end
endmodule : psw_parity

// [rtl/psw_nvm.sv]
// nonvolatile store with parallel erase and program
`timescale 1ns/10ps
`include "psw_params.svh"
module psw_nvm #(
    parameter int unsigned PROG_CYC = `PSW_PROG_TIME_MS * `PSW_CLK_KHZ
) (
    // clock and resets
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic nv_clear_n_i,
    // store commands
    input wire logic erase_i,
    input wire logic prog_i,
    input wire psw_pkg::psw_cfg_s wdata_i,
    input wire logic lock_wr_i,
    input wire logic [1:0] lock_i,
    // contents
    output psw_pkg::psw_cfg_s stored_o,
    output logic [1:0] lock_o,
    output logic busy_o
);
    localparam int unsigned CW = $clog2(PROG_CYC + 1);

    generate
        if (PROG_CYC < 1) begin : g_chk
            $error("psw_nvm: store time must be at least one cycle");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic erase_r;
    logic erase_nxt;
    psw_pkg::psw_cfg_s stored_r;
    psw_pkg::psw_cfg_s stored_nxt;
    psw_pkg::psw_cfg_s pend_r;
    psw_pkg::psw_cfg_s pend_nxt;
    logic [1:0] lock_r;
    logic [1:0] lock_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // whole array is touched at once; lock cells are never erased or programmed
    always_comb begin
        cnt_nxt = cnt_r;
        erase_nxt = erase_r;
        pend_nxt = pend_r;
        stored_nxt = stored_r;
        lock_nxt = lock_r;
        if (lock_wr_i) begin
            lock_nxt = lock_i;
        end
        if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
            if (cnt_r == CW'(1)) begin
                stored_nxt = erase_r ? '0 : (stored_r | pend_r);
            end
        end else if (erase_i || prog_i) begin
            cnt_nxt = CW'(PROG_CYC);
            erase_nxt = erase_i;
            pend_nxt = wdata_i;
        end
    end

    // control state follows the power-on reset
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
            erase_r <= 1'b0;
            pend_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            erase_r <= erase_nxt;
            pend_r <= pend_nxt;
        end
    end

    // cell contents survive the power-on reset; of the two resets only the clear input blanks them
    always_ff @(posedge clk_i or negedge nv_clear_n_i) begin
        if (!nv_clear_n_i) begin
            stored_r <= '0;
            lock_r <= 2'h0;
        end else begin
            stored_r <= stored_nxt;
            lock_r <= lock_nxt;
        end
    end

    assign stored_o = stored_r;
    assign lock_o = lock_r;
    assign busy_o = (cnt_r != '0);
endmodule : psw_nvm

// [rtl/psw_regmap.sv]
// register map of the programmable switch, reached by decoded telegrams
`timescale 1ns/10ps
`include "psw_params.svh"
module psw_regmap #(
    parameter int unsigned PROG_CYC = `PSW_PROG_TIME_MS * `PSW_CLK_KHZ
) (
    // clock and resets
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic nv_clear_n_i,
    // decoded telegram from the supply line
    input wire logic tel_valid_i,
    input wire psw_pkg::psw_tel_s tel_i,
    // answer to the output pin
    output logic ans_valid_o,
    output psw_pkg::psw_ans_s ans_o,
    // activate pulse from the output pin
    input wire logic act_pin_i,
    // readouts from the signal path
    input wire logic [13:0] conv_sample_i,
    input wire logic [13:0] sig_path_i,
    // settings and status
    output psw_pkg::psw_cfg_s cfg_o,
    output logic lock_active_o,
    output logic active_o,
    output logic store_busy_o
);
    generate
        if (PROG_CYC < 1) begin : g_chk
            $error("psw_regmap: store time must be at least one cycle");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // nonvolatile store and parity checkers

    psw_pkg::psw_cfg_s nv_stored;
    logic [1:0] nv_lock;
    logic nv_busy;
    logic nv_erase;
    logic nv_prog;
    logic nv_lock_wr;
    logic cmd_par;
    logic adr_par;
    logic dat_par;
    logic rd_par;
    logic [13:0] rd_dat;

    // the cells are written from the working registers as a whole
    psw_nvm #(.PROG_CYC(PROG_CYC)) u_nvm (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .nv_clear_n_i(nv_clear_n_i),
        .erase_i(nv_erase),
        .prog_i(nv_prog),
        .wdata_i(cfg_o),
        .lock_wr_i(nv_lock_wr),
        .lock_i(tel_i.data_field[1:0]),
        .stored_o(nv_stored),
        .lock_o(nv_lock),
        .busy_o(nv_busy)
    );

    psw_parity #(.W(3), .ODD_ZEROS(1'b1)) u_cpar (
        .bits_i(tel_i.command),
        .par_o(cmd_par)
    );
    psw_parity #(.W(4), .ODD_ZEROS(1'b1)) u_apar (
        .bits_i(tel_i.address),
        .par_o(adr_par)
    );
    psw_parity #(.W(14), .ODD_ZEROS(1'b0)) u_dpar (
        .bits_i(tel_i.data_field),
        .par_o(dat_par)
    );
    psw_parity #(.W(14), .ODD_ZEROS(1'b0)) u_rpar (
        .bits_i(rd_dat),
        .par_o(rd_par)
    );

    ////////////////////////////////////////////////////////////////////////////
    // activate pin: three stages, a change counts when the last two agree

    // pin idles low, so a zero reset level gives no false edge
    logic [2:0] act_sync_r;
    logic [2:0] act_sync_nxt;
    logic act_lvl_r;
    logic act_lvl_nxt;
    logic act_rise;

    always_comb begin
        act_sync_nxt = {act_sync_r[1:0], act_pin_i};
        act_lvl_nxt = act_lvl_r;
        act_rise = 1'b0;
        if (act_sync_r[1] == act_sync_r[2] && act_sync_r[2] != act_lvl_r) begin
            act_lvl_nxt = act_sync_r[2];
            act_rise = act_sync_r[2];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            act_sync_r <= 3'h0;
            act_lvl_r <= 1'b0;
        end else begin
            act_sync_r <= act_sync_nxt;
            act_lvl_r <= act_lvl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // telegram decode and working registers

    psw_pkg::psw_state_e state_r;
    psw_pkg::psw_state_e state_nxt;
    psw_pkg::psw_cfg_s cfg_nxt;
    psw_pkg::psw_ans_s ans_nxt;
    logic ans_valid_nxt;
    logic lock_active_nxt;
    logic active_nxt;
    // gp_idx_r walks the three upper words
    logic [1:0] gp_idx_r;
    logic [1:0] gp_idx_nxt;
    logic [13:0] wd;
    logic take;
    logic ack;
    logic is_rd;
    logic [13:0] sp_rev;

    // reversal kept apart so the read mux stays a plain table
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            sp_rev[i] = sig_path_i[13-i];
        end
    end

    always_comb begin
        state_nxt = state_r;
        cfg_nxt = cfg_o;
        lock_active_nxt = lock_active_o;
        active_nxt = active_o;
        gp_idx_nxt = gp_idx_r;
        ans_nxt = ans_o;
        ans_valid_nxt = 1'b0;
        nv_erase = 1'b0;
        nv_prog = 1'b0;
        nv_lock_wr = 1'b0;
        ack = 1'b0;
        is_rd = 1'b0;
        rd_dat = 14'h0000;
        wd = tel_i.data_field;
        // a corrupted command or address field drops the whole telegram silently
        // boot and store cycles take no telegram either
        take = tel_valid_i && active_o && state_r == psw_pkg::ST_RUN
            && cmd_par == tel_i.command_parity
            && adr_par == tel_i.address_parity;
        case (state_r)
            psw_pkg::ST_BOOT: begin
                // cells are copied to the working registers once per power-up
                cfg_nxt = nv_stored;
                lock_active_nxt = |nv_lock;
                state_nxt = psw_pkg::ST_RUN;
            end
            psw_pkg::ST_STORE: begin
                // telegrams are dropped until the whole array is written
                if (!nv_busy) begin
                    state_nxt = psw_pkg::ST_RUN;
                end
            end
            default: begin
                if (take) begin
                    case (tel_i.command)
                        `PSW_CMD_READ: begin
                            ack = 1'b1;
                            is_rd = 1'b1;
                            // read values sit at the top of the field
                            case (tel_i.address)
                                `PSW_ADR_LOW: rd_dat = {cfg_o.low_level, 6'h00};
                                `PSW_ADR_HIGH: rd_dat = {cfg_o.high_level, 5'h00};
                                `PSW_ADR_VOQ: rd_dat = {cfg_o.quiescent_output_offset, 3'h0};
                                `PSW_ADR_GAIN: rd_dat = cfg_o.magnetic_gain;
                                `PSW_ADR_MODE: rd_dat = {cfg_o.operating_configuration, 4'h0};
                                // lock reads the cell, so a new lock shows before power-up
                                `PSW_ADR_LOCK: rd_dat = {nv_lock, 12'h000};
                                `PSW_ADR_CONV: rd_dat = conv_sample_i;
                                `PSW_ADR_GPU: rd_dat =
                                    {cfg_o.general_purpose_upper_words[gp_idx_r], 1'b0};
                                `PSW_ADR_SPATH: rd_dat = sp_rev;
                                `PSW_ADR_TC: rd_dat = {cfg_o.temperature_coefficient, 4'h0};
                                `PSW_ADR_GP0: rd_dat = {cfg_o.general_purpose_word_zero, 1'b0};
                                default: ack = 1'b0;
                            endcase
                        end
                        `PSW_CMD_WRITE: begin
                            // locked parts refuse every write
                            ack = (dat_par == tel_i.data_parity) && !lock_active_o;
                            if (ack) begin
                                // data sits in the low bits; upper bits are ignored
                                case (tel_i.address)
                                    `PSW_ADR_LOW: cfg_nxt.low_level = wd[7:0];
                                    `PSW_ADR_HIGH: cfg_nxt.high_level = wd[8:0];
                                    `PSW_ADR_VOQ: cfg_nxt.quiescent_output_offset = wd[10:0];
                                    `PSW_ADR_GAIN: cfg_nxt.magnetic_gain = wd;
                                    `PSW_ADR_MODE: cfg_nxt.operating_configuration = wd[9:0];
                                    `PSW_ADR_LOCK: nv_lock_wr = 1'b1;
                                    `PSW_ADR_GPU: cfg_nxt.general_purpose_upper_words[gp_idx_r]
                                        = wd[12:0];
                                    `PSW_ADR_TC: cfg_nxt.temperature_coefficient = wd[9:0];
                                    `PSW_ADR_GP0: cfg_nxt.general_purpose_word_zero = wd[12:0];
                                    `PSW_ADR_DISABLE: begin
                                        if (wd[11:0] == `PSW_DISABLE_KEY) begin
                                            active_nxt = 1'b0;
                                        end
                                    end
                                    default: ack = 1'b0;
                                endcase
                            end
                        end
                        `PSW_CMD_ERASE, `PSW_CMD_PROG: begin
                            // address zero names the whole array
                            ack = tel_i.address == `PSW_ADR_STORE && !lock_active_o;
                            if (ack) begin
                                nv_erase = tel_i.command == `PSW_CMD_ERASE;
                                nv_prog = tel_i.command == `PSW_CMD_PROG;
                                state_nxt = psw_pkg::ST_STORE;
                            end
                        end
                        default: ack = 1'b0;
                    endcase
                    // word zero restarts the upper word walk
                    // past the last word the index holds, repeating it
                    if (ack && tel_i.address == `PSW_ADR_GP0) begin
                        gp_idx_nxt = 2'h0;
                    end else if (ack && tel_i.address == `PSW_ADR_GPU
                            && gp_idx_r != `PSW_GP_LAST) begin
                        gp_idx_nxt = gp_idx_r + 2'h1;
                    end
                end
            end
        endcase
        // set wins: a pin wake in the cycle of a deactivate keeps it on
        if (act_rise) begin
            active_nxt = 1'b1;
        end

        // the answer is one pulse; its word stands until the next one
        if (ack) begin
            ans_valid_nxt = 1'b1;
            ans_nxt.has_data = is_rd;
            ans_nxt.data_field = rd_dat;
            ans_nxt.data_parity = is_rd ? rd_par : 1'b0;
        end
    end

    // a power cycle restores the active state and reloads the cells
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= psw_pkg::ST_BOOT;
            cfg_o <= '0;
            lock_active_o <= 1'b0;
            active_o <= 1'b1;
            gp_idx_r <= 2'h0;
            ans_o <= '0;
            ans_valid_o <= 1'b0;
            store_busy_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cfg_o <= cfg_nxt;
            lock_active_o <= lock_active_nxt;
            active_o <= active_nxt;
            gp_idx_r <= gp_idx_nxt;
            ans_o <= ans_nxt;
            ans_valid_o <= ans_valid_nxt;
            store_busy_o <= state_nxt == psw_pkg::ST_STORE;
        end
    end
endmodule : psw_regmap

// [test/psw_programmer.sv]
// programmer model: builds telegrams, checks acknowledge and parity
`timescale 1ns/10ps
module psw_programmer (
    // clock
    input wire logic clk_i,
    // telegram towards the sensor
    output logic tel_valid_o,
    output psw_pkg::psw_tel_s tel_o,
    // answer from the sensor
    input wire logic ans_valid_i,
    input wire psw_pkg::psw_ans_s ans_i
);
    initial begin
        tel_valid_o = 1'h0;
        tel_o = '0;
    end
    // one telegram; bad flips the command parity on purpose
    task automatic send(input logic [2:0] cmd, input logic [3:0] adr, input logic [13:0] dat,
            input logic bad, output logic ack, output logic [13:0] rd, output logic pok);
        @(negedge clk_i);
        tel_o.command = cmd;
        tel_o.command_parity = ~^cmd ^ bad;
        tel_o.address = adr;
        tel_o.address_parity = ^adr;
        tel_o.data_field = dat;
        tel_o.data_parity = ~^dat;
        tel_valid_o = 1'h1;
        @(negedge clk_i);
        // the acknowledge stands one cycle only, so it is taken here
        ack = ans_valid_i;
        rd = ans_i.data_field;
        pok = !ans_i.has_data || ans_i.data_parity === ~^ans_i.data_field;
        tel_valid_o = 1'h0;
        // released lines must not keep the last value
        tel_o = ~tel_o;
        @(negedge clk_i);
    endtask : send
endmodule : psw_programmer

// [test/psw_regmap_checker.sv]
// assertions on the register map ports
`timescale 1ns/10ps
`include "psw_params.svh"
module psw_regmap_checker #(
    parameter int unsigned PROG_CYC = 20
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // telegram and answer
    input wire logic tel_valid_i,
    input wire psw_pkg::psw_tel_s tel_i,
    input wire logic ans_valid_o,
    input wire psw_pkg::psw_ans_s ans_o,
    // pin, readout and status
    input wire logic act_pin_i,
    input wire logic [13:0] sig_path_i,
    input wire psw_pkg::psw_cfg_s cfg_o,
    input wire logic lock_active_o,
    input wire logic active_o,
    input wire logic store_busy_o
);
    logic up_r;
    logic [31:0] busy_n_r;
    logic [13:0] rev_w;
    logic ok_w, wr_w, rd_w, st_w;
    // up_r stays low over the boot edge, whose telegrams are dropped
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_r <= 1'h0;
            busy_n_r <= 32'h0;
        end else begin
            up_r <= 1'h1;
            busy_n_r <= store_busy_o ? busy_n_r + 32'h1 : 32'h0;
        end
    end
    assign rev_w = {<<{sig_path_i}};
    assign ok_w = tel_valid_i && up_r && active_o && !store_busy_o
        && tel_i.command_parity == ~^tel_i.command && tel_i.address_parity == ^tel_i.address;
    assign wr_w = ok_w && !lock_active_o && tel_i.command == `PSW_CMD_WRITE
        && tel_i.data_parity == ~^tel_i.data_field;
    assign rd_w = ok_w && tel_i.command == `PSW_CMD_READ;
    assign st_w = tel_valid_i
        && (tel_i.command == `PSW_CMD_ERASE || tel_i.command == `PSW_CMD_PROG);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_wr(logic [3:0] a);
        wr_w && tel_i.address == a;
    endsequence
    sequence s_rd(logic [3:0] a);
        rd_w && tel_i.address == a;
    endsequence
    ////////////////////////////////////////
    low_write_a: assert property (s_wr(`PSW_ADR_LOW) |=> ans_valid_o && !ans_o.has_data
        && cfg_o.low_level == $past(tel_i.data_field[7:0])) else $error("low write");
    offset_read_a: assert property (s_rd(`PSW_ADR_VOQ) |=> ans_valid_o
        && ans_o.data_field == {cfg_o.quiescent_output_offset, 3'h0}) else $error("offset read");
    path_reverse_a: assert property (s_rd(`PSW_ADR_SPATH) |=>
        ans_o.data_field == $past(rev_w)) else $error("path read");
    ro_write_a: assert property (tel_valid_i && tel_i.command == `PSW_CMD_WRITE
        && tel_i.address inside {`PSW_ADR_CONV, `PSW_ADR_SPATH} |=> !ans_valid_o)
        else $error("readout written");
    answer_parity_a: assert property (ans_valid_o && ans_o.has_data |->
        ans_o.data_parity == ~^ans_o.data_field) else $error("answer parity");
    parity_drop_a: assert property (tel_valid_i
        && tel_i.command_parity != ~^tel_i.command |=> !ans_valid_o) else $error("bad parity");
    sleep_key_a: assert property (s_wr(`PSW_ADR_DISABLE)
        && tel_i.data_field[11:0] == `PSW_DISABLE_KEY |=> ans_valid_o && !active_o)
        else $error("deactivate");
    wake_pin_a: assert property (!active_o && $rose(act_pin_i) |-> ##[1:8] active_o)
        else $error("activate pulse");
    store_start_a: assert property (ok_w && !lock_active_o
        && tel_i.command == `PSW_CMD_ERASE && tel_i.address == `PSW_ADR_STORE
        |=> ans_valid_o && store_busy_o) else $error("erase start");
    store_addr_a: assert property (st_w && tel_i.address != `PSW_ADR_STORE |=> !ans_valid_o)
        else $error("store address");
    store_len_a: assert property (busy_n_r <= PROG_CYC + 4) else $error("store length");
    lock_late_a: assert property (up_r |=> $stable(lock_active_o)) else $error("lock early");
    lock_write_a: assert property (lock_active_o && tel_valid_i
        && tel_i.command == `PSW_CMD_WRITE |=> !ans_valid_o && $stable(cfg_o))
        else $error("locked write");
endmodule : psw_regmap_checker

bind psw_regmap psw_regmap_checker #(.PROG_CYC(PROG_CYC)) u_psw_regmap_checker (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .tel_valid_i(tel_valid_i), .tel_i(tel_i),
    .ans_valid_o(ans_valid_o), .ans_o(ans_o), .act_pin_i(act_pin_i), .sig_path_i(sig_path_i),
    .cfg_o(cfg_o), .lock_active_o(lock_active_o), .active_o(active_o),
    .store_busy_o(store_busy_o)
);

// [test/psw_regmap_test.sv]
// self-checking bench of the register map
`timescale 1ns/10ps
`include "psw_params.svh"
module psw_regmap_test;
    // short store time keeps the run brief
    localparam int unsigned PC = 20;
    localparam logic [3:0] RA [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hB};
    localparam int RW [6] = '{8, 9, 11, 14, 10, 10};
    localparam logic [13:0] RV [6] = '{14'h0FF, 14'h1FF, 14'h400, 14'h2001, 14'h2A5, 14'h2CB};
    localparam logic [12:0] GP [4] = '{13'h1ABC, 13'h0123, 13'h0456, 13'h0789};
    logic clk_i, reset_n_i, nv_clear_n_i, tel_valid_i, ans_valid_o, act_pin_i;
    logic lock_active_o, active_o, store_busy_o, ack, pok;
    logic [13:0] conv_sample_i, sig_path_i, rdat;
    psw_pkg::psw_tel_s tel_i;
    psw_pkg::psw_ans_s ans_o;
    psw_pkg::psw_cfg_s cfg_o, keep;
    int n_fail, n_checks;

    psw_regmap #(.PROG_CYC(PC)) u_psw_regmap (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .nv_clear_n_i(nv_clear_n_i),
        .tel_valid_i(tel_valid_i), .tel_i(tel_i), .ans_valid_o(ans_valid_o), .ans_o(ans_o),
        .act_pin_i(act_pin_i), .conv_sample_i(conv_sample_i), .sig_path_i(sig_path_i),
        .cfg_o(cfg_o), .lock_active_o(lock_active_o), .active_o(active_o),
        .store_busy_o(store_busy_o)
    );
    psw_programmer u_psw_programmer (
        .clk_i(clk_i), .tel_valid_o(tel_valid_i), .tel_o(tel_i), .ans_valid_i(ans_valid_o),
        .ans_i(ans_o)
    );
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic tx(input logic [2:0] c, input logic [3:0] a, input logic [13:0] d,
            input logic b);
        u_psw_programmer.send(c, a, d, b, ack, rdat, pok);
    endtask : tx
    task automatic wr(input logic [3:0] a, input logic [13:0] d);
        tx(`PSW_CMD_WRITE, a, d, 1'h0);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        tx(`PSW_CMD_READ, a, 14'h0, 1'h0);
    endtask : rd
    // erase then program, both at address zero
    task automatic store();
        for (int i = 0; i < 2; i++) begin
            tx(i ? `PSW_CMD_PROG : `PSW_CMD_ERASE, `PSW_ADR_STORE, 14'h0, 1'h0);
            check("store ack", ack, 1'h1);
            check("store busy", store_busy_o, 1'h1);
            for (int k = 0; k < 100 && store_busy_o === 1'h1; k++) @(negedge clk_i);
            check("store done", store_busy_o, 1'h0);
        end
    endtask : store
    ////////////////////////////////////////
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        give_verdict();
    end
    initial begin
        reset_n_i = 1'h0;
        nv_clear_n_i = 1'h0;
        act_pin_i = 1'h0;
        conv_sample_i = 14'h2B3C;
        sig_path_i = 14'h0E71;
        n_fail = 0;
        n_checks = 0;
        repeat (3) @(negedge clk_i);
        nv_clear_n_i = 1'h1;
        reset_n_i = 1'h1;
        repeat (2) @(negedge clk_i);
        check("cfg blank", cfg_o === '0, 1'h1);
        // unused high bits set on every write: they must be ignored
        for (int i = 0; i < 6; i++) wr(RA[i], RV[i] | (14'h3FFF << RW[i]));
        store();
        for (int i = 0; i < 6; i++) begin
            rd(RA[i]);
            check("read data", rdat, RV[i] << (14 - RW[i]));
            check("read parity", pok, 1'h1);
        end
        check("low", cfg_o.low_level, 8'hFF);
        check("high", cfg_o.high_level, 9'h1FF);
        check("offset", cfg_o.quiescent_output_offset, 11'h400);
        check("gain", cfg_o.magnetic_gain, 14'h2001);
        check("tc group", cfg_o.temperature_coefficient.range_group, 2'h2);
        check("tc lin", cfg_o.temperature_coefficient.linear_term, 5'h19);
        check("tc sq", cfg_o.temperature_coefficient.second_order_temp_term, 3'h3);
        check("out mode", cfg_o.operating_configuration.output_behaviour_select, 3'h5);
        check("oc sign", cfg_o.operating_configuration.offset_correction_sign, 1'h0);
        check("range", cfg_o.operating_configuration.range, 2'h2);
        rd(`PSW_ADR_CONV);
        check("conv read", rdat, 14'h2B3C);
        rd(`PSW_ADR_SPATH);
        check("path read", rdat, 14'h239C);
        for (int i = 0; i < 2; i++) begin
            wr(i ? `PSW_ADR_SPATH : `PSW_ADR_CONV, 14'h0001);
            check("ro write", ack, 1'h0);
        end
        tx(`PSW_CMD_WRITE, `PSW_ADR_LOW, 14'h0011, 1'h1);
        check("bad parity", ack, 1'h0);
        check("low kept", cfg_o.low_level, 8'hFF);
        for (int i = 0; i < 4; i++) wr(i ? `PSW_ADR_GPU : `PSW_ADR_GP0, {1'h1, GP[i]});
        store();
        for (int i = 0; i < 4; i++) begin
            rd(i ? `PSW_ADR_GPU : `PSW_ADR_GP0);
            check("gp read", rdat, {GP[i], 1'h0});
        end
        check("gp top", cfg_o.general_purpose_upper_words[2], GP[3]);
        wr(`PSW_ADR_DISABLE, 14'h3123);
        check("wrong key", active_o, 1'h1);
        wr(`PSW_ADR_DISABLE, 14'h380F);
        check("asleep", active_o, 1'h0);
        rd(`PSW_ADR_LOW);
        check("deaf", ack, 1'h0);
        act_pin_i = 1'h1;
        repeat (8) @(negedge clk_i);
        act_pin_i = 1'h0;
        check("pin wake", active_o, 1'h1);
        wr(`PSW_ADR_LOCK, 14'h3FFD);
        rd(`PSW_ADR_LOCK);
        check("lock read", rdat, 14'h1000);
        check("lock late", lock_active_o, 1'h0);
        tx(`PSW_CMD_ERASE, `PSW_ADR_LOW, 14'h0, 1'h0);
        check("erase addr", ack, 1'h0);
        store();
        keep = cfg_o;
        wr(`PSW_ADR_DISABLE, 14'h080F);
        // supply cycle: reset only, nonvolatile cells survive
        reset_n_i = 1'h0;
        repeat (3) @(negedge clk_i);
        reset_n_i = 1'h1;
        repeat (2) @(negedge clk_i);
        check("power wake", active_o, 1'h1);
        check("locked", lock_active_o, 1'h1);
        check("restored", cfg_o === keep, 1'h1);
        wr(`PSW_ADR_LOW, 14'h0000);
        check("locked wr", ack, 1'h0);
        rd(`PSW_ADR_LOW);
        check("locked rd", rdat, 14'h3FC0);
        give_verdict();
    end
endmodule : psw_regmap_test
